// file: common/scan_defines.svh
// Constants for the boundary-scan test logic
`ifndef SCAN_DEFINES_SVH
`define SCAN_DEFINES_SVH
// Instruction field width and encodings
`define INSN_W 3
`define INSN_EXTEST 3'h0
`define INSN_SAMPLE 3'h1
`define INSN_HIGHZ 3'h5
`define INSN_CONTIN 3'h6
`define INSN_BYPASS 3'h7
// Pattern loaded into the instruction shifter on capture
`define INSN_CAPTURE 3'h1
// Boundary chain length and cell positions, index 0 next to tdi
`define BSC_LEN 8
`define BSC_AD4 0
`define BSC_AD5 1
`define BSC_AD_OE 2
`define BSC_AD6 3
`define BSC_AD7 4
`define BSC_ROM_CS 5
`define BSC_ROM_A0 6
`define BSC_ROM_A1 7
// Chain reset value and tms-high edges that force reset
`define BSC_RESET 8'h00
`define TMS_RESET_EDGES 3'h5
`endif

// file: common/scan_pkg.sv
// Types shared by the boundary-scan test logic
package scan_pkg;
   typedef enum logic [15:0] {
      TAP_RESET = 16'h0001,
      TAP_IDLE = 16'h0002,
      TAP_SEL_DR = 16'h0004,
      TAP_CAP_DR = 16'h0008,
      TAP_SHF_DR = 16'h0010,
      TAP_EX1_DR = 16'h0020,
      TAP_PAU_DR = 16'h0040,
      TAP_EX2_DR = 16'h0080,
      TAP_UPD_DR = 16'h0100,
      TAP_SEL_IR = 16'h0200,
      TAP_CAP_IR = 16'h0400,
      TAP_SHF_IR = 16'h0800,
      TAP_EX1_IR = 16'h1000,
      TAP_PAU_IR = 16'h2000,
      TAP_EX2_IR = 16'h4000,
      TAP_UPD_IR = 16'h8000
   } tap_state_t;
endpackage

// file: common/scan_chain_if.sv
// Carrier between the TAP controller and the boundary chain
`include "scan_defines.svh"
interface scan_chain_if;
   logic cap_en;
   logic shf_en;
   logic upd_en;
   logic ser_in;
   logic ser_out;
   logic [`BSC_LEN-1:0] par_in;
   logic [`BSC_LEN-1:0] upd_val;
   modport ctrl (output cap_en, shf_en, upd_en, ser_in, par_in, input ser_out, upd_val);
   modport chain (input cap_en, shf_en, upd_en, ser_in, par_in, output ser_out, upd_val);
endinterface

// file: hdl/boundary_chain.sv
// Boundary-scan shift stages and update latches
`include "scan_defines.svh"
module boundary_chain
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Controller side
   scan_chain_if.chain bus
);
   logic [`BSC_LEN-1:0] shf_q;
   logic [`BSC_LEN-1:0] upd_q;

   // Capture parallel pad values or shift toward tdo
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         shf_q <= `BSC_RESET;
      else if (bus.cap_en)
         shf_q <= bus.par_in; // [R3]
      else if (bus.shf_en)
         shf_q <= {shf_q[`BSC_LEN-2:0], bus.ser_in}; // [R5]
   end

   // Update latches hold the values the pads drive under test
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         upd_q <= `BSC_RESET;
      else if (bus.upd_en)
         upd_q <= shf_q; // [R4]
   end

   // Last ROM address cell feeds tdo
   assign bus.ser_out = shf_q[`BSC_LEN-1]; // [R5]
   assign bus.upd_val = upd_q;
endmodule

// file: hdl/scan_tap_top.sv
// TAP controller, instruction decode and pad control for boundary scan
//
// Notes on behaviour
// R1: A one-bit bypass stage links tdi to tdo when no other register is selected.
// R2: Reset leaves the controller in reset with bypass as the instruction.
// R3: Boundary cells sit on the bus and serial ROM pads to observe and drive them.
// R4: Under external test, a 1 in the enable cell makes the data pads drive.
// R5: Cells follow a fixed interleaved order; last ROM address cell feeds tdo.
// R6: The controller decodes tms and sequences capture, shift and update.
// R7: The full sixteen-state TAP machine is implemented; the tester drives tms and tck.
// R8: A three-bit instruction register selects data register and test mode.
// R9: Codes 000 extest, 001 sample, 110 continuity, 111 bypass; bypass is transparent.
// R10: Code 101 floats the bus and ROM pads; other ports keep working.
// R11: Reserved codes 010, 011, 100 behave like bypass.
`include "scan_defines.svh"
module scan_tap_top
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Test port pins
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   output logic o_tdo,
   output logic o_tdo_oe,
   // Core side of the pads
   input wire logic [3:0] i_core_ad,
   input wire logic i_core_ad_oe,
   input wire logic i_core_rom_cs_n,
   input wire logic [1:0] i_core_rom_addr,
   input wire logic i_core_rom_oe,
   // Pad side
   input wire logic [3:0] i_pad_ad,
   output logic [3:0] o_pad_ad,
   output logic o_pad_ad_oe,
   output logic o_pad_rom_cs_n,
   output logic [1:0] o_pad_rom_addr,
   output logic o_pad_rom_oe
);
   scan_chain_if bsc ();
   scan_pkg::tap_state_t state_q;
   scan_pkg::tap_state_t state_d;
   logic [2:0] tck_s;
   logic [1:0] tms_s;
   logic [1:0] tdi_s;
   logic [3:0] pad_s1;
   logic [3:0] pad_s2;
   logic rise;
   logic fall;
   logic [`INSN_W-1:0] test_instruction_field;
   logic [`INSN_W-1:0] ir_shf_q;
   logic byp_q;
   logic sel_bsc;
   logic drive_scan;
   logic [`BSC_LEN-1:0] upd;

   // True when the instruction selects the boundary chain
   function automatic logic bsc_selected(input logic [`INSN_W-1:0] code);
      bsc_selected = (code == `INSN_EXTEST) || (code == `INSN_SAMPLE) ||
         (code == `INSN_CONTIN);
   endfunction

   // True when the instruction hands the pads to the scan cells
   function automatic logic scan_drives(input logic [`INSN_W-1:0] code);
      scan_drives = (code == `INSN_EXTEST) || (code == `INSN_CONTIN);
   endfunction

   // Two-stage synchronisers for the pins, third tck stage for edge detection
   // Reset to the idle pin levels so no false tck edge follows reset
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         tck_s <= 3'h0;
         tms_s <= 2'h3;
         tdi_s <= 2'h3;
         pad_s1 <= 4'h0;
         pad_s2 <= 4'h0;
      end
      else
      begin
         tck_s <= {tck_s[1:0], i_tck};
         tms_s <= {tms_s[0], i_tms};
         tdi_s <= {tdi_s[0], i_tdi};
         pad_s1 <= i_pad_ad;
         pad_s2 <= pad_s1;
      end
   end

   assign rise = tck_s[1] & ~tck_s[2];
   assign fall = ~tck_s[1] & tck_s[2];

   // TAP next-state decode on tms
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         scan_pkg::TAP_RESET: state_d = tms_s[1] ? scan_pkg::TAP_RESET : scan_pkg::TAP_IDLE;
         scan_pkg::TAP_IDLE: state_d = tms_s[1] ? scan_pkg::TAP_SEL_DR : scan_pkg::TAP_IDLE;
         scan_pkg::TAP_SEL_DR: state_d = tms_s[1] ? scan_pkg::TAP_SEL_IR : scan_pkg::TAP_CAP_DR;
         scan_pkg::TAP_CAP_DR: state_d = tms_s[1] ? scan_pkg::TAP_EX1_DR : scan_pkg::TAP_SHF_DR;
         scan_pkg::TAP_SHF_DR: state_d = tms_s[1] ? scan_pkg::TAP_EX1_DR : scan_pkg::TAP_SHF_DR;
         scan_pkg::TAP_EX1_DR: state_d = tms_s[1] ? scan_pkg::TAP_UPD_DR : scan_pkg::TAP_PAU_DR;
         scan_pkg::TAP_PAU_DR: state_d = tms_s[1] ? scan_pkg::TAP_EX2_DR : scan_pkg::TAP_PAU_DR;
         scan_pkg::TAP_EX2_DR: state_d = tms_s[1] ? scan_pkg::TAP_UPD_DR : scan_pkg::TAP_SHF_DR;
         scan_pkg::TAP_UPD_DR: state_d = tms_s[1] ? scan_pkg::TAP_SEL_DR : scan_pkg::TAP_IDLE;
         scan_pkg::TAP_SEL_IR: state_d = tms_s[1] ? scan_pkg::TAP_RESET : scan_pkg::TAP_CAP_IR;
         scan_pkg::TAP_CAP_IR: state_d = tms_s[1] ? scan_pkg::TAP_EX1_IR : scan_pkg::TAP_SHF_IR;
         scan_pkg::TAP_SHF_IR: state_d = tms_s[1] ? scan_pkg::TAP_EX1_IR : scan_pkg::TAP_SHF_IR;
         scan_pkg::TAP_EX1_IR: state_d = tms_s[1] ? scan_pkg::TAP_UPD_IR : scan_pkg::TAP_PAU_IR;
         scan_pkg::TAP_PAU_IR: state_d = tms_s[1] ? scan_pkg::TAP_EX2_IR : scan_pkg::TAP_PAU_IR;
         scan_pkg::TAP_EX2_IR: state_d = tms_s[1] ? scan_pkg::TAP_UPD_IR : scan_pkg::TAP_SHF_IR;
         scan_pkg::TAP_UPD_IR: state_d = tms_s[1] ? scan_pkg::TAP_SEL_DR : scan_pkg::TAP_IDLE;
         default: state_d = scan_pkg::TAP_RESET;
      endcase
   end

   // TAP state advances on each tck rising edge
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         state_q <= scan_pkg::TAP_RESET; // [R2]
      else if (rise)
         state_q <= state_d; // [R7]
   end

   // Instruction shifter: capture fixed pattern, shift toward tdo
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         ir_shf_q <= `INSN_CAPTURE;
      else if (rise && state_q == scan_pkg::TAP_CAP_IR)
         ir_shf_q <= `INSN_CAPTURE;
      else if (rise && state_q == scan_pkg::TAP_SHF_IR)
         ir_shf_q <= {tdi_s[1], ir_shf_q[`INSN_W-1:1]}; // [R8]
   end

   // Instruction register: bypass on reset, loaded on the update falling edge
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || state_q == scan_pkg::TAP_RESET)
         test_instruction_field <= `INSN_BYPASS; // [R2]
      else if (fall && state_q == scan_pkg::TAP_UPD_IR)
         test_instruction_field <= ir_shf_q; // [R8]
   end

   assign sel_bsc = bsc_selected(test_instruction_field); // [R9] [R11]
   assign drive_scan = scan_drives(test_instruction_field); // [R4]

   // One-bit bypass stage, captures 0 as usual
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         byp_q <= 1'h0;
      else if (rise && state_q == scan_pkg::TAP_CAP_DR)
         byp_q <= 1'h0;
      else if (rise && state_q == scan_pkg::TAP_SHF_DR)
         byp_q <= tdi_s[1]; // [R1]
   end

   // Control strobes and capture values for the boundary chain
   assign bsc.cap_en = rise && sel_bsc && state_q == scan_pkg::TAP_CAP_DR; // [R6]
   assign bsc.shf_en = rise && sel_bsc && state_q == scan_pkg::TAP_SHF_DR; // [R6]
   assign bsc.upd_en = fall && sel_bsc && state_q == scan_pkg::TAP_UPD_DR; // [R6]
   assign bsc.ser_in = tdi_s[1];
   assign bsc.par_in = {i_core_rom_addr[1], i_core_rom_addr[0], i_core_rom_cs_n,
      pad_s2[3], pad_s2[2], i_core_ad_oe, pad_s2[1], pad_s2[0]}; // [R3] [R5]

   boundary_chain u_chain
   (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .bus(bsc)
   );

   assign upd = bsc.upd_val;

   // Test data output changes on tck falling edge, enabled only while shifting
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         o_tdo <= 1'h0;
         o_tdo_oe <= 1'h0;
      end
      else if (fall)
      begin
         o_tdo_oe <= (state_q == scan_pkg::TAP_SHF_DR) ||
            (state_q == scan_pkg::TAP_SHF_IR); // [R6]
         if (state_q == scan_pkg::TAP_SHF_IR)
            o_tdo <= ir_shf_q[0];
         else if (sel_bsc)
            o_tdo <= bsc.ser_out; // [R5]
         else
            o_tdo <= byp_q; // [R1] [R11]
      end
   end

   // Pad drivers: core values normally, cell values under test, floated on highz
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         o_pad_ad <= 4'h0;
         o_pad_ad_oe <= 1'h0;
         o_pad_rom_cs_n <= 1'h1;
         o_pad_rom_addr <= 2'h0;
         o_pad_rom_oe <= 1'h0;
      end
      else if (test_instruction_field == `INSN_HIGHZ)
      begin
         o_pad_ad <= i_core_ad;
         o_pad_ad_oe <= 1'h0; // [R10]
         o_pad_rom_cs_n <= i_core_rom_cs_n;
         o_pad_rom_addr <= i_core_rom_addr;
         o_pad_rom_oe <= 1'h0; // [R10]
      end
      else if (drive_scan)
      begin
         o_pad_ad <= {upd[`BSC_AD7], upd[`BSC_AD6], upd[`BSC_AD5], upd[`BSC_AD4]};
         o_pad_ad_oe <= upd[`BSC_AD_OE]; // [R4]
         o_pad_rom_cs_n <= upd[`BSC_ROM_CS];
         o_pad_rom_addr <= {upd[`BSC_ROM_A1], upd[`BSC_ROM_A0]};
         o_pad_rom_oe <= 1'h1; // [R3]
      end
      else
      begin
         o_pad_ad <= i_core_ad; // [R9]
         o_pad_ad_oe <= i_core_ad_oe;
         o_pad_rom_cs_n <= i_core_rom_cs_n;
         o_pad_rom_addr <= i_core_rom_addr;
         o_pad_rom_oe <= i_core_rom_oe;
      end
   end

   // Helper: consecutive tck rises seen with tms high
   logic [2:0] tms_hi_cnt;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         tms_hi_cnt <= 3'h0;
      else if (rise)
         tms_hi_cnt <= !tms_s[1] ? 3'h0 :
            (tms_hi_cnt == `TMS_RESET_EDGES) ? tms_hi_cnt : tms_hi_cnt + 3'h1;
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   sequence seq_fall_in(scan_pkg::tap_state_t st);
      fall && state_q == st;
   endsequence

   sequence seq_shift_bypass;
      seq_fall_in(scan_pkg::TAP_SHF_DR) and !sel_bsc;
   endsequence

   chk_reset_bypass: assert property (disable iff (1'b0) i_sys_rst |=> // [R2]
      test_instruction_field == `INSN_BYPASS && state_q == scan_pkg::TAP_RESET)
      else $error("reset did not select bypass");
   chk_tms_reset: assert property (tms_hi_cnt == `TMS_RESET_EDGES |-> // [R7]
      state_q == scan_pkg::TAP_RESET)
      else $error("five tms-high edges did not reach reset");
   chk_bypass_tdo: assert property (seq_shift_bypass |=> o_tdo == $past(byp_q) && o_tdo_oe) // [R1]
      else $error("bypass stage not on tdo");
   chk_chain_tdo: assert property (seq_fall_in(scan_pkg::TAP_SHF_DR) and sel_bsc |=> // [R5]
      o_tdo == $past(bsc.ser_out))
      else $error("boundary chain end not on tdo");
   chk_ir_load: assert property (seq_fall_in(scan_pkg::TAP_UPD_IR) |=> // [R8]
      test_instruction_field == $past(ir_shf_q))
      else $error("instruction not loaded on update");
   chk_highz_pads: assert property (test_instruction_field == `INSN_HIGHZ [*2] |-> // [R10]
      !o_pad_ad_oe && !o_pad_rom_oe)
      else $error("pads not floated under highz");
   chk_extest_oe: assert property (test_instruction_field == `INSN_EXTEST && // [R4]
      upd[`BSC_AD_OE] |=> o_pad_ad_oe)
      else $error("enable cell did not drive pads");
   chk_bypass_pass: assert property (!i_sys_rst && !drive_scan && // [R9] [R11]
      test_instruction_field != `INSN_HIGHZ |=> o_pad_ad == $past(i_core_ad) &&
      o_pad_ad_oe == $past(i_core_ad_oe))
      else $error("bypass disturbed system pads");
   chk_tdo_idle: assert property (fall && state_q != scan_pkg::TAP_SHF_DR && // [R6]
      state_q != scan_pkg::TAP_SHF_IR |=> !o_tdo_oe)
      else $error("tdo driven outside shift");
endmodule

// file: tb/scan_tester.sv
// Board tester model that drives the test port pins
module scan_tester
(
   // Test port pins
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   input wire logic i_tdo,
   input wire logic i_tdo_oe
);
   timeunit 1ns;
   timeprecision 1ns;

   // Clock stands low between frames, select and data idle high
   initial
   begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end

   // One tck period; pins change mid low phase, tdo is taken just before the rise
   task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
      #80;
      o_tms = tms;
      o_tdi = tdi;
      #120;
      tdo = i_tdo;
      oe = i_tdo_oe;
      o_tck = 1'b1;
      #120;
      o_tck = 1'b0;
   endtask

   // Walk from Idle through one IR or DR scan, LSB first, and back to Idle
   task automatic scan(input logic ir, input int n, input logic [7:0] din,
      output logic [7:0] dout, output logic oe_all);
      logic t;
      logic o;
      dout = 8'h00;
      oe_all = 1'b1;
      step(1'b1, 1'b0, t, o);
      if (ir)
         step(1'b1, 1'b0, t, o);
      step(1'b0, 1'b0, t, o);
      step(1'b0, 1'b0, t, o);
      for (int k = 0; k < n; k++)
      begin
         step(k == n - 1, din[k], t, o);
         dout[k] = t;
         oe_all = oe_all & o;
      end
      step(1'b1, 1'b0, t, o);
      step(1'b0, 1'b0, t, o);
   endtask
endmodule

// file: tb/tb_boundary_scan_test_logic.sv
// Self-checking bench for the boundary-scan test logic
`include "scan_defines.svh"
module tb_boundary_scan_test_logic;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_sys_clk;
   logic i_sys_rst;
   logic tck, tms, tdi, o_tdo, o_tdo_oe;
   logic [3:0] core_ad, pad_in, o_pad_ad;
   logic core_ad_oe, core_cs_n, core_rom_oe, o_pad_ad_oe, o_pad_rom_cs_n, o_pad_rom_oe;
   logic [1:0] core_addr, o_pad_rom_addr;
   logic [8:0] pads_now;
   logic [8:0] core_exp;
   logic [7:0] d;
   logic oe;
   int fails = 0;
   int n_checks = 0;

   scan_tap_top uut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_tck(tck),
      .i_tms(tms), .i_tdi(tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_core_ad(core_ad),
      .i_core_ad_oe(core_ad_oe), .i_core_rom_cs_n(core_cs_n), .i_core_rom_addr(core_addr),
      .i_core_rom_oe(core_rom_oe), .i_pad_ad(pad_in), .o_pad_ad(o_pad_ad),
      .o_pad_ad_oe(o_pad_ad_oe), .o_pad_rom_cs_n(o_pad_rom_cs_n),
      .o_pad_rom_addr(o_pad_rom_addr), .o_pad_rom_oe(o_pad_rom_oe));
   scan_tester tst (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(o_tdo),
      .i_tdo_oe(o_tdo_oe));

   // Packed pad outputs and the core values they follow outside test modes
   assign pads_now = {o_pad_rom_oe, o_pad_rom_cs_n, o_pad_rom_addr, o_pad_ad_oe, o_pad_ad};
   assign core_exp = {core_rom_oe, core_cs_n, core_addr, core_ad_oe, core_ad};

   // System clock, 40 ns period
   initial
   begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end

   task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Chain order is tdi side first, so reverse for the LSB-first shifter
   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int k = 0; k < 8; k++)
         rev[k] = v[7 - k];
   endfunction

   // Let pad registers settle past the last detected tck fall
   task automatic settle();
      repeat (3) @(posedge i_sys_clk);
      #1;
   endtask

   task automatic load_ir(input logic [2:0] code);
      tst.scan(1'b1, 3, {5'h00, code}, d, oe);
      cmp(9'(d[2:0]), 9'(`INSN_CAPTURE));
   endtask

   task automatic t_reset();
      settle();
      cmp(pads_now, core_exp);
      cmp(9'(o_tdo_oe), 9'h000);
      tst.step(1'b0, 1'b0, d[0], oe);
      tst.scan(1'b0, 2, 8'h03, d, oe);
      cmp(9'(d[1:0]), 9'h002);
   endtask

   task automatic t_bypass();
      load_ir(`INSN_BYPASS);
      tst.scan(1'b0, 4, 8'h0B, d, oe);
      cmp(9'(d[3:0]), 9'h006);
      cmp(9'(oe), 9'h001);
      settle();
      cmp(pads_now, core_exp);
   endtask

   task automatic t_sample();
      logic [7:0] cells;
      cells = {core_addr, core_cs_n, pad_in[3:2], core_ad_oe, pad_in[1:0]};
      load_ir(`INSN_SAMPLE);
      tst.scan(1'b0, 8, rev(8'hB6), d, oe);
      cmp(9'(rev(d)), 9'(cells));
      settle();
      cmp(pads_now, core_exp);
   endtask

   task automatic t_drive(input logic [2:0] code);
      logic [7:0] p;
      load_ir(code);
      for (int i = 0; i < 2; i++)
      begin
         p = (i == 0) ? 8'hB6 : 8'h4B;
         tst.scan(1'b0, 8, rev(p), d, oe);
         settle();
         cmp(pads_now, {1'b1, p[5], p[7:6], p[2], p[4:3], p[1:0]});
      end
   endtask

   task automatic t_tms_reset();
      for (int i = 0; i < 5; i++)
         tst.step(1'b1, 1'b0, d[0], oe);
      settle();
      cmp(pads_now, core_exp);
      tst.step(1'b0, 1'b0, d[0], oe);
   endtask

   task automatic t_highz();
      load_ir(`INSN_HIGHZ);
      tst.scan(1'b0, 2, 8'h03, d, oe);
      cmp(9'(d[1:0]), 9'h002);
      settle();
      cmp(pads_now, core_exp & 9'h0EF);
   endtask

   task automatic t_reserved();
      for (int c = 2; c < 5; c++)
      begin
         @(posedge i_sys_clk);
         core_ad <= 4'(c + 3);
         settle();
         load_ir(3'(c));
         tst.scan(1'b0, 2, 8'h03, d, oe);
         cmp(9'(d[1:0]), 9'h002);
         settle();
         cmp(pads_now, core_exp);
      end
   endtask

   // Hang guard
   initial
   begin
      #1000000;
      fails++;
      conclude();
   end

   // Main sequence
   initial
   begin
      i_sys_rst = 1'b1;
      core_ad = 4'hA;
      core_ad_oe = 1'b1;
      core_cs_n = 1'b0;
      core_addr = 2'h2;
      core_rom_oe = 1'b1;
      pad_in = 4'h5;
      repeat (2) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      t_reset();
      t_bypass();
      t_sample();
      t_drive(`INSN_EXTEST);
      t_tms_reset();
      t_drive(`INSN_CONTIN);
      t_tms_reset();
      t_highz();
      t_reserved();
      conclude();
   end
endmodule
